/* File: hdl/tasr_pkg.sv */
// Types shared by the tamper/alarm register slice
package tasr_pkg;
  typedef logic [15:0] tasr_word_t;
  typedef enum logic [1:0] {
    TASR_ACC_NONE,
    TASR_ACC_CTRL_WR,
    TASR_ACC_CTRL_RD,
    TASR_ACC_RESULT_RD
  } tasr_access_e;
endpackage

/* File: hdl/tasr_regs.svh */
// Offsets, field positions, reset values and opcodes of the tamper/alarm register slice
`ifndef TASR_REGS_SVH
`define TASR_REGS_SVH
`define TASR_OP_CTRL_WRITE 8'hFF
`define TASR_OP_CTRL_READ 8'h7F
`define TASR_ADDR_WAVE_RATIO_UP 8'hC4
`define TASR_BIT_TAMPER 8
`define TASR_BIT_ALARM 9
`define TASR_CTRL_RESET 12'h000
`define TASR_RESULT_RESET 16'h0000
`endif

/* File: hdl/tasr_regs_bank.sv */
// Control/status register and upstream wave-ratio result register
//
// How it works
// - Control register via opcodes FFh/7Fh, resets zero except the HW_REVISION field in bits 3:0
// - Tamper sets bit 8; written zero re-arms
// - Result registers are read-only to host
// - Reset clears every result register to zero
`include "tasr_regs.svh"
module tasr_regs_bank #(
  parameter logic [3:0] HW_REVISION = 4'h1 // Arbitrary revision value
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [15:0] cmd_wdata,
  input wire logic case_switch_input,
  input wire logic alarm_match,
  input wire logic result_load,
  input wire logic [15:0] result_wave_ratio,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic tamper_latched,
  output logic alarm_match_latched,
  output logic tamper_interrupt_flag,
  output logic alarm_interrupt_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic op_hit(input logic valid, input logic [7:0] op,
    input logic [7:0] code);
    op_hit = valid && (op == code);
  endfunction

  tasr_pkg::tasr_access_e acc;
  wire logic is_ctrl_wr = op_hit(cmd_valid, cmd_opcode, `TASR_OP_CTRL_WRITE);
  wire logic is_ctrl_rd = op_hit(cmd_valid, cmd_opcode, `TASR_OP_CTRL_READ);
  wire logic is_res_rd = op_hit(cmd_valid, cmd_opcode, `TASR_ADDR_WAVE_RATIO_UP);
  wire logic rd_hit = is_ctrl_rd || is_res_rd;
  assign acc = is_ctrl_wr ? tasr_pkg::TASR_ACC_CTRL_WR :
               is_ctrl_rd ? tasr_pkg::TASR_ACC_CTRL_RD :
               is_res_rd ? tasr_pkg::TASR_ACC_RESULT_RD : tasr_pkg::TASR_ACC_NONE;

  logic tamper_q, alarm_q, case_prev_q;
  tasr_pkg::tasr_word_t wave_ratio_q;
  wire logic tamper_evt = case_switch_input && !case_prev_q;
  wire logic wr_sel = (acc == tasr_pkg::TASR_ACC_CTRL_WR);
  wire logic tamper_clr = wr_sel && !cmd_wdata[`TASR_BIT_TAMPER];
  wire logic alarm_clr = wr_sel && !cmd_wdata[`TASR_BIT_ALARM];

  // Set wins over a write of zero
  wire logic tamper_d = tamper_evt || (tamper_q && !tamper_clr);
  wire logic alarm_d = alarm_match || (alarm_q && !alarm_clr);
  wire tasr_pkg::tasr_word_t ctrl_view =
    {6'h00, alarm_q, tamper_q, 4'h0, HW_REVISION};

  logic [15:0] rd_d;
  always_comb
  begin
    case (acc)
      tasr_pkg::TASR_ACC_CTRL_RD: rd_d = ctrl_view;
      tasr_pkg::TASR_ACC_RESULT_RD: rd_d = wave_ratio_q;
      default: rd_d = rd_data;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Case switch edge detector
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      case_prev_q <= 1'b0;
    end
    else
    begin
      case_prev_q <= case_switch_input;
    end
  end

  // Tamper latch and its flag
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tamper_q <= 1'b0;
      tamper_interrupt_flag <= 1'b0;
    end
    else
    begin
      tamper_q <= tamper_d;
      tamper_interrupt_flag <= tamper_evt;
    end
  end

  // Alarm latch and its flag
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      alarm_q <= 1'b0;
      alarm_interrupt_flag <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_d;
      alarm_interrupt_flag <= alarm_match;
    end
  end

  // Upstream wave ratio, loaded by the engine only
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wave_ratio_q <= `TASR_RESULT_RESET;
    end
    else if (result_load)
    begin
      wave_ratio_q <= result_wave_ratio;
    end
  end

  // Read port
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data <= rd_d;
      rd_valid <= rd_hit;
    end
  end

  assign tamper_latched = tamper_q;
  assign alarm_match_latched = alarm_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_tamper_same_cycle: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(tamper_interrupt_flag) |-> tamper_latched)
    else $error("tamper latch not set with flag");

  a_tamper_holds: assert property (@(posedge clk_sys) disable iff (reset)
    tamper_latched && !(is_ctrl_wr && !cmd_wdata[8]) |=> tamper_latched)
    else $error("tamper latch dropped without write");

  a_tamper_clear: assert property (@(posedge clk_sys) disable iff (reset)
    is_ctrl_wr && !cmd_wdata[8] && !tamper_evt |=> !tamper_latched)
    else $error("tamper latch not cleared");

  a_tamper_event: assert property (@(posedge clk_sys) disable iff (reset)
    tamper_evt |=> tamper_interrupt_flag && tamper_latched)
    else $error("tamper event not latched");

  a_alarm_same_cycle: assert property (@(posedge clk_sys) disable iff (reset)
    alarm_interrupt_flag |-> alarm_match_latched)
    else $error("alarm latch not set with flag");

  a_alarm_clear: assert property (@(posedge clk_sys) disable iff (reset)
    is_ctrl_wr && !cmd_wdata[9] && !alarm_match |=> !alarm_match_latched)
    else $error("alarm latch not cleared");

  a_alarm_holds: assert property (@(posedge clk_sys) disable iff (reset)
    alarm_match_latched && !(is_ctrl_wr && !cmd_wdata[9]) |=> alarm_match_latched)
    else $error("alarm latch dropped without write");

  a_alarm_event: assert property (@(posedge clk_sys) disable iff (reset)
    alarm_match |=> alarm_interrupt_flag && alarm_match_latched)
    else $error("alarm match not latched");

  a_result_ro: assert property (@(posedge clk_sys) disable iff (reset)
    !result_load |=> $stable(wave_ratio_q))
    else $error("result changed by host");

  a_result_load: assert property (@(posedge clk_sys) disable iff (reset)
    result_load |=> wave_ratio_q == $past(result_wave_ratio))
    else $error("result not loaded");

  a_result_read: assert property (@(posedge clk_sys) disable iff (reset)
    is_res_rd |=> rd_valid && rd_data == $past(wave_ratio_q))
    else $error("result read wrong");

  a_result_reset: assert property (@(posedge clk_sys)
    reset |=> wave_ratio_q == 16'h0000)
    else $error("result not cleared at reset");

  a_ctrl_read: assert property (@(posedge clk_sys) disable iff (reset)
    is_ctrl_rd |=> rd_valid && rd_data[15:10] == 6'h00 && rd_data[7:4] == 4'h0)
    else $error("control read wrong");

  a_ctrl_bits: assert property (@(posedge clk_sys) disable iff (reset)
    is_ctrl_rd |=> rd_data[9:8] == $past({alarm_match_latched, tamper_latched}))
    else $error("control latch bits wrong");

  a_ctrl_rev: assert property (@(posedge clk_sys) disable iff (reset)
    is_ctrl_rd |=> rd_data[3:0] == HW_REVISION)
    else $error("revision field wrong");

  a_read_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !rd_hit |=> !rd_valid && $stable(rd_data))
    else $error("read port moved without read");

  a_write_silent: assert property (@(posedge clk_sys) disable iff (reset)
    is_ctrl_wr |=> !rd_valid)
    else $error("write gave read strobe");

  a_ctrl_reset: assert property (@(posedge clk_sys)
    reset |=> !tamper_latched && !alarm_match_latched)
    else $error("control not zero after reset");

  a_port_reset: assert property (@(posedge clk_sys)
    reset |=> !rd_valid && !tamper_interrupt_flag && !alarm_interrupt_flag)
    else $error("outputs not zero after reset");
endmodule

/* File: verification/tasr_host.sv */
// Host model issuing register opcodes
module tasr_host (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd_valid = 1'b0;
  initial cmd_opcode = 8'h00;
  initial cmd_wdata = 16'h0000;
  // One-cycle command strobe
  task automatic issue(input logic [7:0] op, input logic [15:0] wd);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_wdata = wd;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask
endmodule

/* File: verification/tasr_regs_bank_bench.sv */
// Bench for the tamper/alarm register slice
module tasr_regs_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic case_switch_input = 1'b0;
  logic alarm_match = 1'b0;
  logic result_load = 1'b0;
  logic [15:0] result_wave_ratio = 16'hA5C3;
  logic cmd_valid, rd_valid, tamper_latched, alarm_match_latched;
  logic tamper_interrupt_flag, alarm_interrupt_flag;
  logic [7:0] cmd_opcode;
  logic [15:0] cmd_wdata, rd_data;
  int num_errors = 0;
  int compares = 0;
  always #25 clk_sys = ~clk_sys;
  tasr_host tasr_host_i (.clk_sys, .cmd_valid, .cmd_opcode, .cmd_wdata);
  tasr_regs_bank tasr_regs_bank_i (.clk_sys, .reset, .cmd_valid, .cmd_opcode, .cmd_wdata,
    .case_switch_input, .alarm_match, .result_load, .result_wave_ratio, .rd_data, .rd_valid,
    .tamper_latched, .alarm_match_latched, .tamper_interrupt_flag, .alarm_interrupt_flag);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] op, input logic [15:0] exp);
    tasr_host_i.issue(op, 16'h0000);
    check(rd_valid, 16'h0001, "rd_valid");
    @(posedge clk_sys) #1 check(rd_data, exp, "rd_data");
    check(rd_valid, 16'h0000, "rd_valid");
  endtask
  task automatic t_tamper();
    @(negedge clk_sys) case_switch_input = 1'b1;
    @(posedge clk_sys) #1 check({tamper_interrupt_flag, tamper_latched}, 2'b11, "tamper");
    @(negedge clk_sys) case_switch_input = 1'b0;
    rd(8'h7F, 16'h0101);
    tasr_host_i.issue(8'hFF, 16'h0000);
    rd(8'h7F, 16'h0001);
  endtask
  task automatic t_alarm();
    @(negedge clk_sys) alarm_match = 1'b1;
    @(posedge clk_sys) #1 check({alarm_interrupt_flag, alarm_match_latched}, 2'b11, "alarm");
    @(negedge clk_sys) alarm_match = 1'b0;
    tasr_host_i.issue(8'hFF, 16'h0200);
    rd(8'h7F, 16'h0201);
    tasr_host_i.issue(8'hFF, 16'h0000);
    rd(8'h7F, 16'h0001);
  endtask
  task automatic t_result();
    @(negedge clk_sys) result_load = 1'b1;
    @(negedge clk_sys) result_load = 1'b0;
    tasr_host_i.issue(8'hFF, 16'hFFFF);
    rd(8'hC4, 16'hA5C3);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'b0;
    rd(8'h7F, 16'h0001);
    rd(8'hC4, 16'h0000);
    t_tamper();
    t_alarm();
    t_result();
    stop_test();
  end
endmodule
